// >>> hpp_regs.vh
`ifndef HPP_REGS_VH
`define HPP_REGS_VH
// host register select codes
`define HPP_SEL_CTRL   3'h0
`define HPP_SEL_STAT   3'h1
`define HPP_SEL_DATA   3'h2
// field positions of the status word
`define HPP_STAT_RXF   0
`define HPP_STAT_TXE   1
`define HPP_STAT_REQ   2
// reset values
`define HPP_RST_BYTE   8'h00
`define HPP_RST_PINS   12'h000
`endif

// >>> hpp_top.v
// Operation
// - eight-bit parallel host data bus attaches directly to host bus
// - host data lines float while enable strobe is deasserted
// - drive data lines only when read high and enable asserted
// - also drive data lines when acknowledge asserted during our request
// - three-bit register select picks the host register accessed
// - read moves data to host, write accepts data, both strobe qualified
// - data pins become general bits zero to seven when port unselected
// - select pins are general bits eight to ten, read/write bit eleven
// - during reset the shared pins are general pins, driven only where gpio_dir is set
// - host write data captured at rising edge of enable strobe
// - open-drain request output asks external party for service
// - acknowledge input serves as dma handshake or interrupt acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "hpp_regs.vh"
module hpp_top #(
   parameter W = 8
) (
   // clock, reset, enable
   input  wire         clk,
   input  wire         rst_n,
   input  wire         ce,
   // configuration
   input  wire         host_mode,
   input  wire [11:0]  gpio_dir,
   input  wire [11:0]  gpio_out,
   output reg  [11:0]  gpio_in,
   // shared data pins
   input  wire [W-1:0] host_data_bus_i,
   output reg  [W-1:0] host_data_bus_o,
   output wire [W-1:0] host_data_bus_oe,
   // shared control pins
   input  wire         host_enable_strobe_n,
   input  wire         host_read_not_write_i,
   output wire         host_read_not_write_o,
   output wire         host_read_not_write_oe,
   input  wire [2:0]   host_register_select_i,
   output wire [2:0]   host_register_select_o,
   output wire [2:0]   host_register_select_oe,
   input  wire         host_acknowledge_n,
   output wire         host_request_n_o,
   output wire         host_request_n_oe,
   // core side, to host
   input  wire [W-1:0] tx_data,
   input  wire         tx_valid,
   output wire         tx_ready,
   input  wire         req_assert,
   input  wire [W-1:0] ctrl_in,
   // core side, from host
   output reg  [W-1:0] rx_data,
   output wire         rx_valid,
   input  wire         rx_ready,
   output reg  [W-1:0] ctrl_reg_r
);
   // two-stage synchronisers for every pin input
   reg [W+5:0] s1_r, s2_r;
   always @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= {(W+6){1'b1}};
         s2_r <= {(W+6){1'b1}};
      end else if (ce) begin
         s1_r <= {host_acknowledge_n, host_register_select_i, host_read_not_write_i,
                  host_enable_strobe_n, host_data_bus_i};
         s2_r <= s1_r;
      end
   end
   wire [W-1:0] d_s    = s2_r[W-1:0];
   wire         en_n_s = s2_r[W];
   wire         rw_s   = s2_r[W+1];
   wire [2:0]   sel_s  = s2_r[W+4:W+2];
   wire         ack_n_s = s2_r[W+5];

   // host mode only takes effect after reset, pins follow gpio_dir meanwhile
   reg hm_r;
   always @(posedge clk) begin
      if (!rst_n)
         hm_r <= 1'b0;
      else if (ce)
         hm_r <= host_mode;
   end

   // two-entry rx buffer, host to core
   reg [W-1:0] rb_r [0:1];
   reg [1:0]   rcnt_r;
   reg         rwp_r, rrp_r;
   // two-entry tx buffer, core to host
   reg [W-1:0] tb_r [0:1];
   reg [1:0]   tcnt_r;
   reg         twp_r, trp_r;
   reg         en_d_r;
   reg [2:0]   sel_l_r;
   // data is synced alongside the strobe, so hold the last word seen while it was low
   reg [W-1:0] d_l_r;
   reg         rw_l_r;
   reg         req_r;
   reg [11:0]  gin_nxt;

   assign rx_valid = (rcnt_r != 2'h0);
   assign tx_ready = (tcnt_r != 2'h2);
   always @* rx_data = rb_r[rrp_r];

   // access ends on the rising edge of the strobe; rw held steady by host
   wire strobe_rise = hm_r & en_n_s & ~en_d_r;
   wire wr_acc  = strobe_rise & ~rw_l_r;
   wire rd_acc  = strobe_rise &  rw_l_r;
   wire dma_acc = hm_r & req_r & ~ack_n_s;
   wire wr_data = wr_acc & (sel_l_r == `HPP_SEL_DATA);
   // a write to a full buffer is dropped; host must poll status first
   wire rpush = wr_data & (rcnt_r != 2'h2);
   wire rpop  = rx_valid & rx_ready;
   wire tpop  = rd_acc & (sel_l_r == `HPP_SEL_DATA) & (tcnt_r != 2'h0);
   wire tpush = tx_valid & tx_ready;

   always @(posedge clk) begin
      if (!rst_n) begin
         en_d_r <= 1'b1;
         sel_l_r <= 3'h0;
         d_l_r <= `HPP_RST_BYTE;
         rw_l_r <= 1'b0;
         rcnt_r <= 2'h0;
         rwp_r <= 1'b0;
         rrp_r <= 1'b0;
         tcnt_r <= 2'h0;
         twp_r <= 1'b0;
         trp_r <= 1'b0;
         req_r <= 1'b0;
         ctrl_reg_r <= `HPP_RST_BYTE;
         rb_r[0] <= `HPP_RST_BYTE;
         rb_r[1] <= `HPP_RST_BYTE;
         tb_r[0] <= `HPP_RST_BYTE;
         tb_r[1] <= `HPP_RST_BYTE;
      end else if (ce) begin
         en_d_r <= en_n_s;
         if (!en_n_s) begin
            sel_l_r <= sel_s;
            d_l_r <= d_s;
            rw_l_r <= rw_s;
         end
         if (wr_acc && sel_l_r == `HPP_SEL_CTRL)
            ctrl_reg_r <= d_l_r;
         if (rpush) begin
            rb_r[rwp_r] <= d_l_r;
            rwp_r <= ~rwp_r;
         end
         if (rpop)
            rrp_r <= ~rrp_r;
         rcnt_r <= rcnt_r + {1'b0, rpush} - {1'b0, rpop};
         if (tpush) begin
            tb_r[twp_r] <= tx_data;
            twp_r <= ~twp_r;
         end
         if (tpop)
            trp_r <= ~trp_r;
         tcnt_r <= tcnt_r + {1'b0, tpush} - {1'b0, tpop};
         req_r <= hm_r & req_assert;
      end
   end

   // read data mux, registered so the pins see stable data
   always @(posedge clk) begin
      if (!rst_n)
         host_data_bus_o <= `HPP_RST_BYTE;
      else if (ce) begin
         if (!hm_r)
            host_data_bus_o <= gpio_out[7:0];
         else if (dma_acc || sel_s == `HPP_SEL_DATA)
            host_data_bus_o <= tb_r[trp_r];
         else if (sel_s == `HPP_SEL_STAT)
            host_data_bus_o <= {{(W-3){1'b0}}, req_r, (tcnt_r == 2'h0),
                                rx_valid};
         else
            host_data_bus_o <= ctrl_in;
      end
   end

   // output enables: in host mode data uses strobe, rw and dma ack and select and rw pins stay undriven, else gpio direction
   wire host_drv = (~en_n_s & rw_s) | dma_acc;
   assign host_data_bus_oe = hm_r ? {W{host_drv}} : gpio_dir[7:0];
   assign host_register_select_o  = gpio_out[10:8];
   assign host_register_select_oe = hm_r ? 3'h0 : gpio_dir[10:8];
   assign host_read_not_write_o   = gpio_out[11];
   assign host_read_not_write_oe  = hm_r ? 1'b0 : gpio_dir[11];
   // open drain: only ever drive low
   assign host_request_n_o  = 1'b0;
   assign host_request_n_oe = req_r;

   always @* begin
      gin_nxt = {rw_s, sel_s, d_s};
   end
   always @(posedge clk) begin
      if (!rst_n)
         gpio_in <= `HPP_RST_PINS;
      else if (ce)
         gpio_in <= gin_nxt;
   end
endmodule // hpp_top
`default_nettype wire

// >>> hpp_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module hpp_top_props #(parameter W = 8) (
   // watched pins
   input wire logic         clk, rst_n, host_mode, req_assert, rx_valid,
   input wire logic         host_enable_strobe_n, host_acknowledge_n, host_read_not_write_i,
   input wire logic         host_read_not_write_oe, host_request_n_o, host_request_n_oe,
   input wire logic [2:0]   host_register_select_oe,
   input wire logic [W-1:0] host_data_bus_oe,
   input wire logic [11:0]  gpio_dir
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire hm = host_mode, sn = host_enable_strobe_n, an = host_acknowledge_n;
   wire rw = host_read_not_write_i, rq = host_request_n_oe;
   wire [W-1:0] oe = host_data_bus_oe;
   // pins pass a two-stage synchroniser, so causes must hold three cycles
   property p_idle; (hm && sn && an) [*3] |-> oe == 0; endproperty
   a_idle: assert property (p_idle) else $error("idle bus driven");
   property p_rd; (hm && !sn && rw && an) [*3] |-> &oe; endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_wr; (hm && !sn && !rw && an) [*3] |-> oe == 0; endproperty
   a_wr: assert property (p_wr) else $error("write driven");
   property p_ack; (hm && !an && rq) [*3] |-> &oe; endproperty
   a_ack: assert property (p_ack) else $error("ack not driven");
   property p_req; hm ##1 (hm && req_assert) |=> rq && !host_request_n_o; endproperty
   a_req: assert property (p_req) else $error("no request");
   property p_gp; !hm [*2] |->
      {host_read_not_write_oe, host_register_select_oe, oe} == gpio_dir; endproperty
   a_gp: assert property (p_gp) else $error("general dir");
   property p_hp; hm [*2] |-> !host_read_not_write_oe && host_register_select_oe == 0; endproperty
   a_hp: assert property (p_hp) else $error("select driven");
   property p_rst; disable iff (1'b0) !rst_n |=> oe == 0 && !rq && !rx_valid; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   c_rd: cover property (!sn && &oe);
   c_ack: cover property (!an && rq);
   c_rx: cover property (rx_valid);
endmodule // hpp_top_props
bind hpp_top hpp_top_props #(.W(W)) u_props (.*);
`default_nettype wire

// >>> hpp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
   // host side of the pins
   input wire logic       clk,
   input wire logic [7:0] oe, o,
   output var logic [7:0] bus, d,
   output var logic       stb_n, rw, drv, ack_n,
   output var logic [2:0] sel
);
   logic [7:0] last;
   // a floating bit shows the inverse of its last level, never a lucky match
   always_comb bus = (oe & o) | (~oe & (drv ? d : ~last));
   always @(posedge clk) last <= bus;
   initial {stb_n, ack_n, rw, drv, sel, d} = 14'h3000;
   task acc(input logic r, input logic [2:0] s, input logic [7:0] w, output logic [7:0] q);
      @(posedge clk) {stb_n, rw, sel, d, drv} <= {1'b0, r, s, w, !r};
      repeat (5) @(posedge clk);
      q = bus;
      {stb_n, drv} <= 2'h2;
      repeat (4) @(posedge clk);
   endtask
endmodule // hpp_host_model
`default_nettype wire

// >>> hpp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpp_regs.vh"
module hpp_top_tb;
   logic clk = 0, rst_n = 0, ce = 1, host_mode = 1, tx_valid = 0, rx_ready = 0, req_assert = 0;
   logic [11:0] gpio_dir = 0, gpio_out = 0, gpio_in;
   logic [7:0] tx_data = 0, ctrl_in = 0, rx_data, ctrl_reg_r, v, e, host_data_bus_i;
   logic [7:0] host_data_bus_o, host_data_bus_oe;
   logic [2:0] host_register_select_i, host_register_select_o, host_register_select_oe;
   logic host_enable_strobe_n, host_read_not_write_i, host_read_not_write_o, tx_ready;
   logic host_read_not_write_oe, host_acknowledge_n, host_request_n_o, host_request_n_oe;
   logic rx_valid;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   logic [7:0] q[$];
   always #5 clk = ~clk;
   hpp_host_model h (.clk(clk), .oe(host_data_bus_oe), .o(host_data_bus_o),
      .bus(host_data_bus_i), .d(), .drv(), .stb_n(host_enable_strobe_n),
      .rw(host_read_not_write_i), .ack_n(host_acknowledge_n), .sel(host_register_select_i));
   hpp_top uut (.*);
   task chk(input logic [11:0] g, x);
      cmp_count++;
      if (g !== x) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
   endtask
   task end_sim;
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim;
      end
   end
   initial begin
      void'($urandom(32'hEF1D));
      repeat (6) @(posedge clk);
      rst_n <= 1;
      @(posedge clk) #1 chk({tx_ready, rx_valid, host_data_bus_oe}, 12'h200);
      // three writes into a stalled two-word buffer: the third is dropped
      repeat (3) begin
         e = $urandom;
         h.acc(0, `HPP_SEL_DATA, e, v);
         if (q.size() < 2) q.push_back(e);
      end
      while (q.size()) begin
         #1 chk({rx_valid, rx_data}, {1'b1, q.pop_front()});
         @(posedge clk) rx_ready <= 1;
         @(posedge clk) rx_ready <= 0;
      end
      #1 chk(rx_valid, 0);
      @(posedge clk) tx_valid <= 1;
      repeat (2) begin
         e = $urandom;
         q.push_back(e);
         tx_data <= e;
         @(posedge clk);
      end
      tx_valid <= 0;
      #1 chk(tx_ready, 0);
      repeat (2) begin
         h.acc(1, `HPP_SEL_DATA, 0, v);
         chk(v, q.pop_front());
      end
      e = $urandom;
      @(posedge clk) {req_assert, tx_valid, tx_data} <= {2'h3, e};
      @(posedge clk) {tx_valid, h.ack_n} <= 2'h0;
      repeat (5) @(posedge clk);
      v = host_data_bus_i;
      h.ack_n <= 1;
      chk(v, e);
      h.acc(1, `HPP_SEL_STAT, 0, v);
      chk(v, 8'h04);
      ctrl_in <= 8'($urandom);
      h.acc(1, `HPP_SEL_CTRL, 0, v);
      chk(v, ctrl_in);
      e = $urandom;
      h.acc(0, `HPP_SEL_CTRL, e, v);
      chk(ctrl_reg_r, e);
      {host_mode, req_assert, gpio_dir[7:0], gpio_out, h.d, h.drv} <= {2'h0, e, 20'($urandom), 1'b1};
      repeat (8) @(posedge clk);
      #1 chk({host_read_not_write_oe, host_register_select_oe, host_read_not_write_o,
         host_register_select_o}, {gpio_dir[11:8], gpio_out[11:8]});
      chk(gpio_in, {host_read_not_write_i, host_register_select_i,
         (gpio_dir[7:0] & gpio_out[7:0]) | (~gpio_dir[7:0] & h.d)});
      end_sim;
   end
endmodule // hpp_top_tb
`default_nettype wire
